// file: logic/adccal_cor_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// raw result in, corrected result out
interface adccal_cor_if;
	logic [23:0] raw;
	logic        rawVld;
	logic [23:0] offs;
	logic [23:0] gain;
	logic [23:0] res;
	logic        resVld;
	modport ctl (output raw, rawVld, offs, gain, input res, resVld);
	modport cor (input raw, rawVld, offs, gain, output res, resVld);
endinterface
`default_nettype wire

// file: logic/adccal_corrector.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// offset subtract then gain multiply, one cycle, saturating
module adccal_corrector (
	input  wire logic   clk,  // core clock
	input  wire logic   srst, // sync reset
	adccal_cor_if.cor   cif   // raw in, result out
);
	typedef struct packed {
		logic [23:0] res;
		logic        vld;
	} adccal_cor_s;

	adccal_cor_s r_ff;
	adccal_cor_s nxt_r;

	// subtract offset first, then scale by full-scale word
	always_comb begin
		logic signed [24:0] diff;
		logic signed [49:0] prod;
		logic        [26:0] sc;
		diff = '0;
		prod = '0;
		sc = '0;
		nxt_r = r_ff;
		diff = $signed({cif.raw[23], cif.raw}) - $signed({cif.offs[23], cif.offs});
		prod = diff * $signed({1'b0, cif.gain});
		sc = prod[adccal_pkg::GAIN_SHIFT +: 27];
		nxt_r.vld = cif.rawVld;
		if (cif.rawVld) begin
			if (sc[26:23] == 4'h0 || sc[26:23] == 4'hF) begin
				nxt_r.res = sc[23:0];
			end else if (sc[26]) begin
				nxt_r.res = 24'h800000;
			end else begin
				nxt_r.res = 24'h7FFFFF;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign cif.res = r_ff.res;
	assign cif.resVld = r_ff.vld;
endmodule
`default_nettype wire

// file: logic/adccal_pkg.sv
package adccal_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [7:0]  ADDR_MODE  = 8'h00;
	localparam logic [7:0]  ADDR_CONF  = 8'h04;
	localparam logic [7:0]  ADDR_GPO   = 8'h08;
	localparam logic [7:0]  ADDR_STAT  = 8'h0C;
	localparam logic [7:0]  ADDR_DATA  = 8'h10;
	localparam logic [7:0]  ADDR_OFFS  = 8'h14;
	localparam logic [7:0]  ADDR_FSC   = 8'h18;
	// ==========================================================
	// mode register fields
	localparam int          MODE_W     = 18;
	localparam int          MD_SEL_LSB = 0;
	localparam int          MD_PAR     = 3;
	localparam int          MD_APP     = 4;
	localparam int          MD_CHOP    = 5;
	localparam int          MD_SINC3   = 6;
	localparam int          MD_CLKDIV  = 7;
	localparam int          MD_FS_LSB  = 8;
	// ==========================================================
	// configuration, output control and status fields
	localparam int          CFG_W      = 5;
	localparam int          CF_TEMP    = 0;
	localparam int          CF_BIP     = 1;
	localparam int          CF_GN_LSB  = 2;
	localparam int          GP_LEN     = 0;
	localparam int          GP_UEN     = 1;
	localparam int          GP_DAT_LSB = 4;
	localparam int          ST_NRDY    = 7;
	localparam int          ST_PAR     = 4;
	localparam int          ST_POS     = 24;
	// ==========================================================
	// mode select codes
	localparam logic [2:0]  MS_CONT    = 3'h0;
	localparam logic [2:0]  MS_IDLE    = 3'h2;
	localparam logic [2:0]  MS_IZS     = 3'h4;
	localparam logic [2:0]  MS_IFS     = 3'h5;
	localparam logic [2:0]  MS_SZS     = 3'h6;
	localparam logic [2:0]  MS_SFS     = 3'h7;
	// ==========================================================
	// settling time in output periods
	localparam logic [3:0]  SET_SINC4  = 4'h4;
	localparam logic [3:0]  SET_SINC3  = 4'h3;
	localparam logic [3:0]  SET_CHOP   = 4'h2;
	// ==========================================================
	// reset values and scaling
	localparam logic [17:0] RST_MODE   = 18'h00000;
	localparam logic [4:0]  RST_CFG    = 5'h02;
	localparam logic [7:0]  RST_GPO    = 8'h00;
	localparam logic [23:0] RST_OFFS   = 24'h000000;
	localparam logic [23:0] RST_FSC    = 24'h800000;
	localparam logic [23:0] MID_SCALE  = 24'h800000;
	localparam int          GAIN_SHIFT = 23;
	localparam logic [5:0]  SYNC_INIT  = 6'h03;

	typedef enum logic {ST_IDLE, ST_CAL} adccal_state_e;
endpackage

// file: logic/adccal_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// three-stage pin sampler, level taken once stages two and three agree
module adccal_sync3 #(
	parameter int          W    = 6,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,  // core clock
	input  wire logic         srst, // sync reset
	input  wire logic [W-1:0] din,  // asynchronous pins
	output logic      [W-1:0] lvl   // filtered level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} adccal_syn_s;

	adccal_syn_s r_ff;
	adccal_syn_s nxt_r;
	logic [W-1:0] agree;

	// stage shift and agreement filter
	always_comb begin
		nxt_r = r_ff;
		agree = ~(r_ff.s2 ^ r_ff.s3);
		nxt_r.s1 = din;
		nxt_r.s2 = r_ff.s1;
		nxt_r.s3 = r_ff.s2;
		nxt_r.lvl = (r_ff.lvl & ~agree) | (r_ff.s3 & agree);
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			r_ff <= {INIT, INIT, INIT, INIT};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign lvl = r_ff.lvl;
endmodule
`default_nettype wire

// file: logic/adccal_top.sv
`timescale 1ns/1ps
`default_nettype none
module adccal_top (
	input  wire logic        clk,           // 200 MHz core clock
	input  wire logic        srst,          // sync reset, high
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb unmapped address
	input  wire logic [23:0] rawData,       // filter result, signed
	input  wire logic        rawValid,      // filter result strobe
	input  wire logic        csN,           // chip select pin
	input  wire logic        syncN,         // sync pin
	input  wire logic [3:0]  gpIn,          // output pin levels back
	output logic      [3:0]  gpOut,         // output pin data
	output logic      [3:0]  gpOutEn,       // output pin enables
	output logic             rdyOut,        // data-out/ready pin level
	output logic             tempSensorSel, // sensor to converter
	output logic             calZeroSel,    // internal zero input
	output logic             calFullSel,    // internal full input
	output logic             filterRst      // modulator/filter reset
);
	// ==========================================================
	// state
	typedef struct packed {
		adccal_pkg::adccal_state_e st;
		logic [3:0]                cnt;
		logic [3:0]                target;
		logic [17:0]               mode;
		logic [4:0]                cfg;
		logic [7:0]                gpo;
		logic [23:0]               offs;
		logic [23:0]               fsc;
		logic [23:0]               data;
		logic                      notRdy;
		logic                      parity;
		logic                      rdy;
		logic                      fltRst;
		logic                      calZ;
		logic                      calF;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} adccal_top_s;

	adccal_top_s r_ff;
	adccal_top_s nxt_r;

	logic        setup;
	logic        wrEn;
	logic        rdEn;
	logic        modeWr;
	logic        calReq;
	logic [2:0]  wrSel;
	logic [2:0]  modeSel;
	logic [3:0]  settle;
	logic [23:0] coded;
	logic [7:0]  statByte;
	logic [5:0]  pinLvl;

	// ==========================================================
	// pin sampling: {gpIn, syncN, csN}
	adccal_sync3 #(
		.W    (6),
		.INIT (adccal_pkg::SYNC_INIT)
	) uSync (
		.clk  (clk),
		.srst (srst),
		.din  ({gpIn, syncN, csN}),
		.lvl  (pinLvl)
	);

	// ==========================================================
	// correction datapath
	adccal_cor_if cif ();

	// raw results go through offset and gain correction
	assign cif.raw = rawData;
	assign cif.rawVld = rawValid;
	assign cif.offs = r_ff.offs;
	assign cif.gain = r_ff.fsc;

	adccal_corrector uCor (
		.clk  (clk),
		.srst (srst),
		.cif  (cif)
	);

	// ==========================================================
	// bus decode and helpers
	assign setup = psel & ~penable;
	assign wrEn = psel & penable & r_ff.pready & pwrite;
	assign rdEn = psel & penable & r_ff.pready & ~pwrite;
	assign modeWr = wrEn & (paddr == adccal_pkg::ADDR_MODE);
	assign wrSel = pwdata[adccal_pkg::MD_SEL_LSB +: 3];
	assign calReq = modeWr & wrSel[2];
	assign modeSel = r_ff.mode[adccal_pkg::MD_SEL_LSB +: 3];

	// settling periods from the mode being written
	always_comb begin
		if (pwdata[adccal_pkg::MD_CHOP]) begin
			settle = adccal_pkg::SET_CHOP;
		end else if (pwdata[adccal_pkg::MD_SINC3]) begin
			settle = adccal_pkg::SET_SINC3;
		end else begin
			settle = adccal_pkg::SET_SINC4;
		end
	end

	// output coding: bipolar is offset binary, unipolar clamps at zero
	always_comb begin
		if (r_ff.cfg[adccal_pkg::CF_BIP]) begin
			coded = cif.res ^ adccal_pkg::MID_SCALE;
		end else if (cif.res[23]) begin
			coded = 24'h000000;
		end else begin
			coded = cif.res;
		end
	end

	// status byte as seen by a read
	assign statByte = {r_ff.notRdy, 2'h0, r_ff.parity, 4'h0};

	// ==========================================================
	// next state
	always_comb begin
		nxt_r = r_ff;
		// one-cycle answer after every setup cycle
		nxt_r.pready = setup;
		nxt_r.pslverr = 1'b0;
		// a low sync pin holds the filter in reset
		nxt_r.fltRst = ~pinLvl[1];
		if (setup) begin
			nxt_r.prdata = '0;
			case (paddr)
				adccal_pkg::ADDR_MODE: begin
					nxt_r.prdata[adccal_pkg::MODE_W-1:0] = r_ff.mode;
				end
				adccal_pkg::ADDR_CONF: begin
					nxt_r.prdata[adccal_pkg::CFG_W-1:0] = r_ff.cfg;
				end
				adccal_pkg::ADDR_GPO: begin
					nxt_r.prdata[1:0] = r_ff.gpo[1:0];
					nxt_r.prdata[adccal_pkg::GP_DAT_LSB +: 4] = pinLvl[5:2];
				end
				adccal_pkg::ADDR_STAT: begin
					nxt_r.prdata[7:0] = statByte;
				end
				adccal_pkg::ADDR_DATA: begin
					nxt_r.prdata[23:0] = r_ff.data;
					if (r_ff.mode[adccal_pkg::MD_APP]) begin
						nxt_r.prdata[31:24] = statByte;
					end
				end
				adccal_pkg::ADDR_OFFS: begin
					nxt_r.prdata[23:0] = r_ff.offs;
				end
				adccal_pkg::ADDR_FSC: begin
					nxt_r.prdata[23:0] = r_ff.fsc;
				end
				default: begin
					nxt_r.pslverr = 1'b1;
				end
			endcase
		end
		// register writes
		if (wrEn) begin
			case (paddr)
				adccal_pkg::ADDR_MODE: begin
					nxt_r.mode = pwdata[adccal_pkg::MODE_W-1:0];
					nxt_r.fltRst = 1'b1;
					nxt_r.st = adccal_pkg::ST_IDLE;
					if (wrSel[2]) begin
						nxt_r.st = adccal_pkg::ST_CAL;
						nxt_r.cnt = 4'h0;
						nxt_r.notRdy = 1'b1;
						nxt_r.target = settle;
						if (wrSel == adccal_pkg::MS_IFS && r_ff.cfg[4:2] != 3'h0) begin
							nxt_r.target = {settle[2:0], 1'b0};
						end
					end
				end
				adccal_pkg::ADDR_CONF: begin
					nxt_r.cfg = pwdata[adccal_pkg::CFG_W-1:0];
					nxt_r.fltRst = 1'b1;
				end
				adccal_pkg::ADDR_GPO: begin
					nxt_r.gpo = {pwdata[7:4], 2'h0, pwdata[1:0]};
				end
				adccal_pkg::ADDR_OFFS: begin
					if (modeSel == adccal_pkg::MS_IDLE) begin
						nxt_r.offs = pwdata[23:0];
					end
				end
				adccal_pkg::ADDR_FSC: begin
					if (modeSel == adccal_pkg::MS_IDLE) begin
						nxt_r.fsc = pwdata[23:0];
					end
				end
				default: begin
					nxt_r.pslverr = 1'b0;
				end
			endcase
		end
		// reading the data register marks it consumed
		if (rdEn && paddr == adccal_pkg::ADDR_DATA) begin
			nxt_r.notRdy = 1'b1;
		end
		// new conversion wins over a read in the same cycle
		if (cif.resVld && r_ff.st == adccal_pkg::ST_IDLE && modeSel == adccal_pkg::MS_CONT
			&& !modeWr) begin
			nxt_r.data = coded;
			nxt_r.parity = r_ff.mode[adccal_pkg::MD_PAR] & (^coded);
			nxt_r.notRdy = 1'b0;
		end
		// calibration counts filter results until settled
		if (r_ff.st == adccal_pkg::ST_CAL && rawValid && !modeWr) begin
			nxt_r.cnt = r_ff.cnt + 4'h1;
			if (r_ff.cnt + 4'h1 == r_ff.target) begin
				if (modeSel[0]) begin
					nxt_r.fsc = rawData;
				end else begin
					nxt_r.offs = rawData;
				end
				nxt_r.notRdy = 1'b0;
				nxt_r.mode[adccal_pkg::MD_SEL_LSB +: 3] = adccal_pkg::MS_IDLE;
				nxt_r.st = adccal_pkg::ST_IDLE;
			end
		end
		// internal inputs only for internal calibrations
		nxt_r.calZ = (nxt_r.st == adccal_pkg::ST_CAL)
			&& (nxt_r.mode[2:0] == adccal_pkg::MS_IZS);
		nxt_r.calF = (nxt_r.st == adccal_pkg::ST_CAL)
			&& (nxt_r.mode[2:0] == adccal_pkg::MS_IFS);
		// pin goes low only when ready and selected
		nxt_r.rdy = nxt_r.notRdy | pinLvl[0];
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			r_ff <= '0;
			r_ff.st <= adccal_pkg::ST_IDLE;
			r_ff.mode <= adccal_pkg::RST_MODE;
			r_ff.cfg <= adccal_pkg::RST_CFG;
			r_ff.gpo <= adccal_pkg::RST_GPO;
			r_ff.offs <= adccal_pkg::RST_OFFS;
			r_ff.fsc <= adccal_pkg::RST_FSC;
			r_ff.notRdy <= 1'b1;
			r_ff.rdy <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ==========================================================
	// outputs, all from flops
	assign prdata = r_ff.prdata;
	assign pready = r_ff.pready;
	assign pslverr = r_ff.pslverr;
	assign gpOut = r_ff.gpo[7:4];
	assign gpOutEn = {{2{r_ff.gpo[1]}}, {2{r_ff.gpo[0]}}};
	assign rdyOut = r_ff.rdy;
	assign tempSensorSel = r_ff.cfg[adccal_pkg::CF_TEMP];
	assign calZeroSel = r_ff.calZ;
	assign calFullSel = r_ff.calF;
	assign filterRst = r_ff.fltRst;

	// ==========================================================
	// checks
	default clocking dc @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_calLast;
		r_ff.st == adccal_pkg::ST_CAL && rawValid && !modeWr
			&& r_ff.cnt + 4'h1 == r_ff.target;
	endsequence

	a_temp_route: assert property (
		wrEn && paddr == adccal_pkg::ADDR_CONF |=> tempSensorSel == $past(pwdata[0]))
		else $error("temp select not applied");
	a_mid_scale: assert property (
		cif.resVld && cif.res == 24'h0 && r_ff.cfg[1] && !modeWr
			&& r_ff.st == adccal_pkg::ST_IDLE && modeSel == adccal_pkg::MS_CONT
		|=> r_ff.data == adccal_pkg::MID_SCALE)
		else $error("zero reading not mid-scale");
	a_gpo_enable: assert property (
		wrEn && paddr == adccal_pkg::ADDR_GPO
		|=> gpOutEn == {{2{$past(pwdata[1])}}, {2{$past(pwdata[0])}}})
		else $error("output pair enable wrong");
	a_gpo_level: assert property (
		wrEn && paddr == adccal_pkg::ADDR_GPO |=> gpOut == $past(pwdata[7:4]))
		else $error("output data wrong");
	a_gpo_readback: assert property (
		setup && !pwrite && paddr == adccal_pkg::ADDR_GPO |=> prdata[7:4] == $past(pinLvl[5:2]))
		else $error("readback not pin level");
	a_filter_reset: assert property (
		wrEn && (paddr == adccal_pkg::ADDR_MODE || paddr == adccal_pkg::ADDR_CONF) |=> filterRst)
		else $error("filter reset missing");
	a_parity_even: assert property (
		rdEn && paddr == adccal_pkg::ADDR_DATA && r_ff.mode[3] && r_ff.mode[4]
		|-> (^{prdata[23:0], prdata[28]}) == 1'b0)
		else $error("odd ones in data read");
	a_cal_start: assert property (
		calReq |=> rdyOut && r_ff.notRdy && r_ff.st == adccal_pkg::ST_CAL)
		else $error("calibration start not flagged");
	a_cal_finish: assert property (
		s_calLast |=> r_ff.st == adccal_pkg::ST_IDLE && !r_ff.notRdy
			&& modeSel == adccal_pkg::MS_IDLE && rdyOut == $past(pinLvl[0]))
		else $error("calibration end wrong");
	a_full_double: assert property (
		calReq && wrSel == adccal_pkg::MS_IFS && r_ff.cfg[4:2] != 3'h0 && !pwdata[5]
			&& !pwdata[6] |=> r_ff.target == 4'h8)
		else $error("full-scale time not doubled");
endmodule
`default_nettype wire

// file: verification/adc_calibration_and_aux_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_and_aux_control_bench;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] rawData;
	logic        rawValid;
	logic        csN = 1'b1;
	logic        syncN = 1'b1;
	logic [3:0]  gpIn;
	logic [3:0]  gpOut;
	logic [3:0]  gpOutEn;
	logic        rdyOut;
	logic        tempSensorSel;
	logic        calZeroSel;
	logic        calFullSel;
	logic        filterRst;
	logic        run = 1'b0;
	logic [23:0] level = 24'h0;
	logic [3:0]  faultMask = 4'h0;
	int          nErrors = 0;
	int          nCompared = 0;
	int          frCnt = 0;
	logic [23:0] mOffs = 24'h0;
	int          mFsc = 32'h800000;
	logic [2:0]  mSel = 3'h0;
	logic [23:0] expQ[$];
	logic [31:0] rd;
	logic        er;
	logic [7:0]  ra[5] = '{adccal_pkg::ADDR_MODE, adccal_pkg::ADDR_CONF, adccal_pkg::ADDR_OFFS,
		adccal_pkg::ADDR_FSC, 8'h1C};
	logic [31:0] rv[5] = '{32'(adccal_pkg::RST_MODE), 32'(adccal_pkg::RST_CFG), 32'h0,
		32'(adccal_pkg::RST_FSC), 32'h0};
	int          cc[8] = '{4, 5, 6, 7, 4, 6, 5, 7};
	int          cf[8] = '{0, 0, 0, 0, 1, 1, 0, 1};
	int          s3[8] = '{0, 0, 1, 1, 0, 0, 0, 0};
	int          gn[8] = '{0, 0, 0, 0, 0, 0, 3, 2};

	// ==========================================================
	// clock, design and far side
	always #2.5 clk = ~clk;

	adccal_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rawData(rawData), .rawValid(rawValid), .csN(csN), .syncN(syncN), .gpIn(gpIn),
		.gpOut(gpOut), .gpOutEn(gpOutEn), .rdyOut(rdyOut), .tempSensorSel(tempSensorSel),
		.calZeroSel(calZeroSel), .calFullSel(calFullSel), .filterRst(filterRst));

	adccal_far_model u_far (.clk(clk), .srst(srst), .run(run), .level(level),
		.faultMask(faultMask), .gpOut(gpOut), .gpOutEn(gpOutEn), .rawData(rawData),
		.rawValid(rawValid), .gpIn(gpIn));

	// ==========================================================
	// reference model: correction of each result, filter reset count
	function automatic logic [23:0] corr(input logic [23:0] r);
		longint d;
		longint p;
		d = longint'($signed(r)) - longint'($signed(mOffs));
		p = (d * mFsc) >>> 23;
		if (p > 64'sd8388607) begin
			p = 64'sd8388607;
		end
		if (p < -64'sd8388608) begin
			p = -64'sd8388608;
		end
		return p[23:0] ^ adccal_pkg::MID_SCALE;
	endfunction

	// expected results queued as the far side delivers them
	always @(posedge clk) begin
		if (rawValid === 1'b1 && mSel == adccal_pkg::MS_CONT) begin
			expQ.push_back(corr(rawData));
		end
		if (filterRst === 1'b1 && syncN) begin
			frCnt++;
		end
	end

	// ==========================================================
	// report, compare and bus tasks
	task automatic summarize;
		$display("compared %0d, errors %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nCompared++;
		if (g !== e) begin
			nErrors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask

	task automatic chkPin(input string nm, input logic e, input logic g);
		nCompared++;
		if (g !== e) begin
			nErrors++;
			$display("unexpected %s: expected %b, seen %b", nm, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				break;
			end
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			chkPin("bus ready", 1'b1, 1'b0);
			summarize();
		end
	endtask

	task automatic strobes(input int n);
		int k;
		int c;
		c = 0;
		for (k = 0; k < 40 * n && c < n; k++) begin
			@(posedge clk);
			if (rawValid === 1'b1) begin
				c++;
			end
		end
		if (c < n) begin
			chk("strobe count", 32'(n), 32'(c));
			summarize();
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int i;
		int k;
		int n;
		int c0;
		logic [3:0]  en;
		logic [7:0]  gv;
		logic [23:0] v;
		logic [31:0] md;
		void'($urandom(37391));
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		csN <= 1'b0;
		// reset values and an unmapped address
		for (i = 0; i < 5; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rv[i], rd);
			chkPin("slverr", i == 4, er);
		end
		// sensor select, with filter reset on the write
		c0 = frCnt;
		apb(1'b1, adccal_pkg::ADDR_CONF, 32'h3);
		repeat (3) @(posedge clk);
		chk("conf filter reset", 32'(c0 + 1), 32'(frCnt));
		chkPin("temp select", 1'b1, tempSensorSel);
		// output pins: every pair enable, then shorted pins
		for (i = 0; i < 8; i++) begin
			faultMask <= (i > 3) ? 4'($urandom) : 4'h0;
			gv = 8'($urandom);
			c0 = frCnt;
			apb(1'b1, adccal_pkg::ADDR_GPO, {24'h0, gv[7:4], 2'b00, 2'(i)});
			en = {i[1], i[1], i[0], i[0]};
			repeat (6) @(posedge clk);
			chk("gpo enables", 32'(en), 32'(gpOutEn));
			chk("gpo data", 32'(gv[7:4] & en), 32'(gpOut & en));
			apb(1'b0, adccal_pkg::ADDR_GPO, 32'h0);
			chk("gpo readback", {24'h0, (gv[7:4] & en) ^ (faultMask & en), 2'b00, 2'(i)},
				rd & 32'hF3);
			chk("gpo no filter reset", 32'(c0), 32'(frCnt));
		end
		// sync pin holds the filter in reset
		syncN <= 1'b0;
		repeat (6) @(posedge clk);
		chkPin("sync reset", 1'b1, filterRst);
		syncN <= 1'b1;
		repeat (6) @(posedge clk);
		chkPin("sync release", 1'b0, filterRst);
		// conversions: unity gain signed, then offset, gain and parity
		for (k = 0; k < 2; k++) begin
			run <= 1'b0;
			apb(1'b1, adccal_pkg::ADDR_MODE, 32'(adccal_pkg::MS_IDLE));
			mSel = adccal_pkg::MS_IDLE;
			mOffs = (k == 1) ? 24'h001234 : 24'h000000;
			mFsc = (k == 1) ? 32'hC00000 : 32'h800000;
			apb(1'b1, adccal_pkg::ADDR_OFFS, 32'(mOffs));
			apb(1'b1, adccal_pkg::ADDR_FSC, 32'(mFsc));
			md = (k == 1) ? 32'h18 : 32'h0;
			apb(1'b1, adccal_pkg::ADDR_MODE, md);
			mSel = adccal_pkg::MS_CONT;
			apb(1'b1, adccal_pkg::ADDR_OFFS, 32'h5A5A5A);
			apb(1'b0, adccal_pkg::ADDR_OFFS, 32'h0);
			chk("offset locked", 32'(mOffs), rd);
			run <= 1'b1;
			for (i = 0; i < 6; i++) begin
				v = 24'($urandom);
				v = (k == 1) ? 24'h010000 + {5'h0, v[18:0]} : {{3{v[20]}}, v[20:0]};
				level <= (i == 0 && k == 0) ? 24'h000000 : v;
				strobes(1);
				repeat (3) @(posedge clk);
				apb(1'b0, adccal_pkg::ADDR_DATA, 32'h0);
				if (k == 0) begin
					chk("data", {8'h0, expQ[$]}, rd);
				end else begin
					chk("data", {8'h0, expQ[$]}, {8'h0, rd[23:0]});
					chkPin("parity", ^expQ[$], rd[28]);
					chkPin("odd ones", 1'b0, ^{rd[23:0], rd[28]});
				end
			end
		end
		// calibrations: each kind, filter order, chop and gain
		for (i = 0; i < 8; i++) begin
			run <= 1'b0;
			apb(1'b1, adccal_pkg::ADDR_CONF, 32'({3'(gn[i]), 2'b10}));
			repeat (2) @(posedge clk);
			n = (cf[i] == 1) ? 2 : ((s3[i] == 1) ? 3 : 4);
			if (cc[i] == 5 && gn[i] != 0) begin
				n = 2 * n;
			end
			v = 24'($urandom);
			level <= v;
			c0 = frCnt;
			md = {14'h0, 10'h010, 1'(cc[i] == 5), 1'(s3[i]), 1'(cf[i]), 2'b00, 3'(cc[i])};
			apb(1'b1, adccal_pkg::ADDR_MODE, md);
			mSel = 3'(cc[i]);
			repeat (2) @(posedge clk);
			chkPin("cal busy pin", 1'b1, rdyOut);
			chkPin("zero input", cc[i] == 4, calZeroSel);
			chkPin("full input", cc[i] == 5, calFullSel);
			chk("cal filter reset", 32'(c0 + 1), 32'(frCnt));
			csN <= 1'(i == 7);
			run <= 1'b1;
			strobes(n - 1);
			apb(1'b0, adccal_pkg::ADDR_STAT, 32'h0);
			chk("busy status", 32'h80, rd & 32'h80);
			strobes(1);
			run <= 1'b0;
			repeat (3) @(posedge clk);
			chkPin("ready pin", 1'(i == 7), rdyOut);
			apb(1'b0, adccal_pkg::ADDR_STAT, 32'h0);
			chk("ready status", 32'h0, rd & 32'h80);
			apb(1'b0, adccal_pkg::ADDR_MODE, 32'h0);
			chk("back to idle", 32'(adccal_pkg::MS_IDLE), rd & 32'h7);
			apb(1'b0, (cc[i] % 2 == 1) ? adccal_pkg::ADDR_FSC : adccal_pkg::ADDR_OFFS, 32'h0);
			chk("coefficient", {8'h0, v}, rd);
		end
		summarize();
	end
endmodule
`default_nettype wire

// file: verification/adccal_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: filter result strobes and output pins
module adccal_far_model (
	input  wire logic        clk,       // core clock
	input  wire logic        srst,      // sync reset
	input  wire logic        run,       // strobes enabled
	input  wire logic [23:0] level,     // next filter result
	input  wire logic [3:0]  faultMask, // shorted pins
	input  wire logic [3:0]  gpOut,     // pin data
	input  wire logic [3:0]  gpOutEn,   // pin enables
	output logic      [23:0] rawData,   // filter result
	output logic             rawValid,  // result strobe
	output logic      [3:0]  gpIn       // pin levels
);
	logic [3:0] cnt_ff;

	// one strobe every twelve cycles, data scrambled between strobes
	always_ff @(posedge clk) begin
		if (srst || !run) begin
			cnt_ff <= 4'h0;
			rawValid <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == 4'hB) ? 4'h0 : cnt_ff + 4'h1;
			rawValid <= (cnt_ff == 4'hB);
		end
		if (srst) begin
			rawData <= 24'h000000;
		end else begin
			rawData <= (cnt_ff == 4'hB && run) ? level : ~rawData;
		end
	end

	// released pins fall to their pull-downs, shorted pins invert
	assign gpIn = gpOutEn & (gpOut ^ faultMask);
endmodule
`default_nettype wire
